// File: core/fwid_flash_dev.sv
// Flash device end: wake, identify, quad-mode switch, parameter table read.
// Assumes the link pins are asynchronous to clk_i and the serial clock is
// much slower than clk_i (half period of eight system cycles or more).
//
// Notes on behaviour
// RULE1 - Opcode abh alone with chip select wakes.
// RULE2 - Reject commands until wake release delay ends.
// RULE3 - Host keeps chip select high during delay.
// RULE4 - Identify read: opcode then three dummy bytes.
// RULE5 - Identity bits leave on falling clock, MSB first.
// RULE6 - Identity byte repeats until chip select rises.
// RULE7 - Identify-with-wake uses the longer release delay.
// RULE8 - Wake/identify ignored while operation busy.
// RULE9 - Opcode 38h enters quad instruction mode.
// RULE10 - Opcode ffh in quad mode leaves it.
// RULE11 - Mode switch keeps latch, suspend, wrap.
// RULE12 - Opcode 5ah returns the parameter table.
// RULE13 - Array bytes read as erased ffh.
// RULE14 - Status delivered zero except bits 21, 9.
// RULE15 - Power-down ignores all but wake, reset.
// RULE16 - Quad mode moves four bits per clock.
// RULE17 - Identity byte is a design parameter.
`timescale 1ns/1ps
module fwid_flash_dev #(
  parameter logic [7:0] IDENTITY_BYTE = 8'h5c,  // Arbitrary value
  parameter int PARAM_BYTES = 8,
  parameter logic [PARAM_BYTES*8-1:0] PARAM_TABLE = 64'h0102030405060708
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  fwid_link_if.dev link,
  input wire logic operation_busy_flag_i,
  input wire logic enter_power_down_i,
  output logic quad_instruction_mode_o,
  output logic deep_power_down_o,
  output logic wake_pending_o,
  output logic [fwid_pkg::STATUS_W-1:0] status_o
);
  typedef enum logic [2:0] {DEV_IDLE, DEV_OPCODE, DEV_LEAD, DEV_TAIL, DEV_OUT, DEV_DROP}
    fwid_dev_state_t;

  if (PARAM_BYTES < 1 || PARAM_BYTES > 256) begin : g_chk
    $error("PARAM_BYTES must lie in 1..256");
  end

  fwid_dev_state_t state;
  logic [2:0] cs_s, sclk_s;
  logic [3:0] io_s1, io_s2, io_s3;
  logic cs_f, sclk_f;
  logic [3:0] io_f;
  logic quad, pd, reset_armed;
  logic [15:0] recover_cnt;
  logic [7:0] opcode, in_sr, in_next, out_sr, cur, byte_src;
  logic [2:0] bit_cnt, out_cnt, lead_cnt;
  logic [3:0] step, bit_sum;
  logic [7:0] tbl_idx;
  logic [3:0] dev_o, dev_oe;
  logic [fwid_pkg::STATUS_W-1:0] status;

  // Number of address/dummy bytes that follow an opcode
  function automatic logic [2:0] lead_of(input logic [7:0] op);
    unique case (op)
      fwid_pkg::OP_WAKE_ID: lead_of = fwid_pkg::ID_DUMMY_BYTES;
      fwid_pkg::OP_PARAM_TABLE: lead_of = fwid_pkg::PARAM_LEAD_BYTES;
      fwid_pkg::OP_READ: lead_of = fwid_pkg::READ_ADDR_BYTES;
      default: lead_of = 3'h0;
    endcase
  endfunction

  // Opcodes that are heard during deep power-down
  function automatic logic wakes_ok(input logic [7:0] op);
    wakes_ok = op == fwid_pkg::OP_WAKE_ID || op == fwid_pkg::OP_RESET_EN ||
      op == fwid_pkg::OP_RESET;
  endfunction

  // Three-stage pin synchronisers
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cs_s <= 3'h7;
      sclk_s <= 3'h0;
      io_s1 <= 4'hf;
      io_s2 <= 4'hf;
      io_s3 <= 4'hf;
    end else begin
      cs_s <= {cs_s[1:0], link.cs_n};
      sclk_s <= {sclk_s[1:0], link.sclk};
      io_s1 <= link.io;
      io_s2 <= io_s1;
      io_s3 <= io_s2;
    end
  end

  // Filtered pin levels: change once second and third stages agree
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cs_f <= 1'b1;
      sclk_f <= 1'b0;
      io_f <= 4'hf;
    end else begin
      if (cs_s[1] == cs_s[2]) cs_f <= cs_s[2];
      if (sclk_s[1] == sclk_s[2]) sclk_f <= sclk_s[2];
      if (io_s2 == io_s3) io_f <= io_s3;
    end
  end

  wire cs_start = cs_s[1] == cs_s[2] && !cs_s[2] && cs_f;
  wire cs_end = cs_s[1] == cs_s[2] && cs_s[2] && !cs_f;
  wire sclk_rise = sclk_s[1] == sclk_s[2] && sclk_s[2] && !sclk_f;
  wire sclk_fall = sclk_s[1] == sclk_s[2] && !sclk_s[2] && sclk_f;
  wire byte_done = bit_sum == fwid_pkg::BITS_PER_BYTE;
  wire addr_last = state == DEV_LEAD && opcode == fwid_pkg::OP_PARAM_TABLE &&
    lead_cnt == fwid_pkg::PARAM_ADDR_LAST_LEFT;

  // Bits per serial clock and incoming shift value
  always_comb begin
    step = quad ? fwid_pkg::STEP_QUAD : fwid_pkg::STEP_SINGLE;  // see RULE16
    bit_sum = {1'b0, bit_cnt} + step;
    in_next = quad ? {in_sr[3:0], io_f} : {in_sr[6:0], io_f[0]};  // see RULE16
  end

  // Frame sequencer: opcode, lead bytes, data phase
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state <= DEV_IDLE;
      opcode <= 8'h00;
      in_sr <= 8'h00;
      bit_cnt <= 3'h0;
      lead_cnt <= 3'h0;
    end else if (cs_end) begin
      state <= DEV_IDLE;
    end else if (cs_start) begin
      state <= recover_cnt == 16'h0000 ? DEV_OPCODE : DEV_DROP;  // see RULE2
      bit_cnt <= 3'h0;
    end else if (sclk_rise) begin
      unique case (state)
        DEV_OPCODE, DEV_LEAD: begin
          in_sr <= in_next;
          bit_cnt <= bit_sum[2:0];
          if (byte_done && state == DEV_OPCODE) begin
            opcode <= in_next;
            lead_cnt <= lead_of(in_next);
            if (pd && !wakes_ok(in_next)) state <= DEV_DROP;  // see RULE15
            else if (in_next == fwid_pkg::OP_WAKE_ID && operation_busy_flag_i)
              state <= DEV_DROP;  // see RULE8
            else if (lead_of(in_next) != 3'h0) state <= DEV_LEAD;  // see RULE4
            else state <= DEV_TAIL;
          end else if (byte_done) begin
            lead_cnt <= lead_cnt - 3'h1;
            if (lead_cnt == 3'h1) state <= DEV_OUT;
          end
        end
        DEV_TAIL: state <= DEV_DROP;  // Clocks after the opcode cancel it
        DEV_IDLE, DEV_OUT, DEV_DROP: ;
      endcase
    end
  end

  // Byte to send next: identity, table entry or erased array
  always_comb begin
    unique case (opcode)
      fwid_pkg::OP_WAKE_ID: byte_src = IDENTITY_BYTE;  // see RULE6, RULE17
      fwid_pkg::OP_PARAM_TABLE:
        byte_src = 32'(tbl_idx) < PARAM_BYTES ?
          PARAM_TABLE[(PARAM_BYTES - 1 - 32'(tbl_idx)) * 8 +: 8] :
          fwid_pkg::ERASED_BYTE;  // see RULE12
      default: byte_src = fwid_pkg::ERASED_BYTE;  // see RULE13
    endcase
    cur = out_cnt == 3'h0 ? byte_src : out_sr;
  end

  // Output driver: shifts on falling serial clock, MSB first
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      dev_o <= 4'h0;
      dev_oe <= 4'h0;
      out_sr <= 8'h00;
      out_cnt <= 3'h0;
      tbl_idx <= 8'h00;
    end else if (cs_end || cs_start) begin
      dev_oe <= 4'h0;
      out_cnt <= 3'h0;
    end else if (sclk_fall && state == DEV_OUT) begin
      if (quad) begin
        dev_o <= cur[7:4];  // see RULE16
        dev_oe <= 4'hf;
      end else begin
        dev_o <= {2'b00, cur[7], 1'b0};  // see RULE5
        dev_oe <= 4'h2;
      end
      out_sr <= cur << step;
      out_cnt <= out_cnt + step[2:0];
      if (out_cnt == 3'h0) tbl_idx <= tbl_idx + 8'h01;
    end else if (sclk_rise && addr_last && byte_done) begin
      tbl_idx <= in_next;
    end
  end

  // Mode, power-down, release delay and status register
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      quad <= 1'b0;
      pd <= 1'b0;
      reset_armed <= 1'b0;
      recover_cnt <= 16'h0000;
      status <= fwid_pkg::STATUS_DELIVERED;  // see RULE14
    end else begin
      status[fwid_pkg::STS_BUSY_BIT] <= operation_busy_flag_i;
      if (recover_cnt != 16'h0000) recover_cnt <= recover_cnt - 16'h0001;  // see RULE2
      if (enter_power_down_i && !operation_busy_flag_i) pd <= 1'b1;
      if (cs_end && state == DEV_TAIL) begin
        reset_armed <= opcode == fwid_pkg::OP_RESET_EN;
        unique case (opcode)
          // Mode flips touch only the mode bit, never status
          fwid_pkg::OP_QUAD_ON: if (!quad) quad <= 1'b1;  // see RULE9, RULE11
          fwid_pkg::OP_QUAD_OFF: if (quad) quad <= 1'b0;  // see RULE10, RULE11
          fwid_pkg::OP_WREN: status[fwid_pkg::STS_WEL_BIT] <= 1'b1;
          fwid_pkg::OP_RESET: if (reset_armed) begin
            quad <= 1'b0;
            pd <= 1'b0;
            status[fwid_pkg::STS_WEL_BIT] <= 1'b0;
          end
          default: ;
        endcase
      end else if (cs_end && (state == DEV_LEAD || state == DEV_OUT)) begin
        reset_armed <= 1'b0;
        if (opcode == fwid_pkg::OP_WAKE_ID && pd) begin
          pd <= 1'b0;  // see RULE1
          // No clock after the opcode: plain wake, short delay
          if (state == DEV_LEAD && lead_cnt == fwid_pkg::ID_DUMMY_BYTES && bit_cnt == 3'h0)
            recover_cnt <= fwid_pkg::WAKE_RELEASE_CYC;  // see RULE2
          else recover_cnt <= fwid_pkg::WAKE_WITH_ID_CYC;  // see RULE7
        end
      end
    end
  end

  // Registered outputs
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      quad_instruction_mode_o <= 1'b0;
      deep_power_down_o <= 1'b0;
      wake_pending_o <= 1'b0;
      status_o <= fwid_pkg::STATUS_DELIVERED;
    end else begin
      quad_instruction_mode_o <= quad;
      deep_power_down_o <= pd;
      wake_pending_o <= recover_cnt != 16'h0000;
      status_o <= status;
    end
  end

  assign link.dev_io_o = dev_o;
  assign link.dev_io_oe = dev_oe;
endmodule

// File: core/fwid_host_ctrl.sv
// Host controller end: runs one command frame per control write.
// Assumes software on Avalon-MM and the flash device on the link.
`timescale 1ns/1ps
module fwid_host_ctrl #(
  parameter int SCLK_HALF = fwid_pkg::SCLK_HALF_CYC
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic [3:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  fwid_link_if.host link
);
  typedef enum logic [2:0] {H_IDLE, H_SELECT, H_XFER, H_DESELECT, H_HOLD} fwid_host_state_t;

  if (SCLK_HALF < 16 || SCLK_HALF > 255) begin : g_chk
    $error("SCLK_HALF must lie in 16..255");
  end

  fwid_host_state_t state;
  logic [7:0] div_cnt, op;
  logic tick, quad, busy, wake, cs_q, sclk_q;
  logic [2:0] dummy, len;
  logic [6:0] cnt, tx_bits, total;
  logic [7:0] tx_sr;
  logic [31:0] rx_sr;
  logic [3:0] io_o, io_oe, step, io_s1, io_s2, io_s3, io_f;
  logic [15:0] hold_cnt;

  wire acc = (avs_read_i || avs_write_i) && !avs_waitrequest_o;
  wire start = acc && avs_write_i && avs_address_i == fwid_pkg::REG_CTRL && !busy;

  assign step = quad ? fwid_pkg::STEP_QUAD : fwid_pkg::STEP_SINGLE;

  // Serial clock half-period enable
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) div_cnt <= 8'h00;
    else if (tick) div_cnt <= 8'h00;
    else div_cnt <= div_cnt + 8'h01;
  end
  assign tick = div_cnt == 8'(SCLK_HALF - 1);

  // Data line synchronisers, three stages, agree filter
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      io_s1 <= 4'hf;
      io_s2 <= 4'hf;
      io_s3 <= 4'hf;
      io_f <= 4'hf;
    end else begin
      io_s1 <= link.io;
      io_s2 <= io_s1;
      io_s3 <= io_s2;
      if (io_s2 == io_s3) io_f <= io_s3;
    end
  end

  // Avalon slave: one wait cycle, then answer
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o <= 32'h0000_0000;
    end else begin
      avs_waitrequest_o <= !((avs_read_i || avs_write_i) && avs_waitrequest_o);
      unique case (avs_address_i)
        fwid_pkg::REG_CTRL: avs_readdata_o <= 32'({wake, 1'b0, len, 1'b0, dummy, op});
        fwid_pkg::REG_STATUS: avs_readdata_o <= 32'({quad, busy});
        fwid_pkg::REG_DATA: avs_readdata_o <= rx_sr;
        default: avs_readdata_o <= 32'h0000_0000;
      endcase
    end
  end

  // Frame sequencer and pin drive
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state <= H_IDLE;
      op <= 8'h00;
      dummy <= 3'h0;
      len <= 3'h0;
      wake <= 1'b0;
      busy <= 1'b0;
      quad <= 1'b0;
      cs_q <= 1'b1;
      sclk_q <= 1'b0;
      cnt <= 7'h00;
      tx_bits <= 7'h00;
      total <= 7'h00;
      tx_sr <= 8'h00;
      rx_sr <= 32'h0000_0000;
      io_o <= 4'h0;
      io_oe <= 4'h0;
      hold_cnt <= 16'h0000;
    end else begin
      unique case (state)
        H_IDLE: if (start) begin
          op <= avs_writedata_i[fwid_pkg::CTRL_OP_LSB +: 8];
          dummy <= avs_writedata_i[fwid_pkg::CTRL_DUMMY_LSB +: 3];
          len <= avs_writedata_i[fwid_pkg::CTRL_LEN_LSB +: 3];
          wake <= avs_writedata_i[fwid_pkg::CTRL_WAKE_BIT];
          tx_sr <= avs_writedata_i[fwid_pkg::CTRL_OP_LSB +: 8];
          tx_bits <= {avs_writedata_i[fwid_pkg::CTRL_DUMMY_LSB +: 3], 3'h0} + 7'h08;
          total <= {avs_writedata_i[fwid_pkg::CTRL_DUMMY_LSB +: 3], 3'h0} + 7'h08 +
            {avs_writedata_i[fwid_pkg::CTRL_LEN_LSB +: 3], 3'h0};
          busy <= 1'b1;
          cs_q <= 1'b0;
          cnt <= 7'h00;
          rx_sr <= 32'h0000_0000;
          state <= H_SELECT;
        end
        H_SELECT: if (tick) begin
          io_o <= quad ? tx_sr[7:4] : {3'b000, tx_sr[7]};  // see RULE16
          io_oe <= quad ? 4'hf : 4'h1;
          tx_sr <= tx_sr << step;
          state <= H_XFER;
        end
        H_XFER: if (tick && !sclk_q) begin
          sclk_q <= 1'b1;
          cnt <= cnt + {3'h0, step};
          if (cnt >= tx_bits)
            rx_sr <= quad ? {rx_sr[27:0], io_f} : {rx_sr[30:0], io_f[1]};  // see RULE5
        end else if (tick) begin
          sclk_q <= 1'b0;
          if (cnt == total) begin
            io_oe <= 4'h0;
            state <= H_DESELECT;
          end else if (cnt < tx_bits) begin
            io_o <= quad ? tx_sr[7:4] : {3'b000, tx_sr[7]};
            tx_sr <= tx_sr << step;
          end else begin
            io_oe <= 4'h0;
          end
        end
        H_DESELECT: if (tick) begin
          cs_q <= 1'b1;  // see RULE1
          if (op == fwid_pkg::OP_QUAD_ON) quad <= 1'b1;  // see RULE9
          if (op == fwid_pkg::OP_QUAD_OFF) quad <= 1'b0;  // see RULE10
          if (!wake) hold_cnt <= fwid_pkg::CS_HIGH_MIN_CYC;
          else if (len != 3'h0)
            hold_cnt <= fwid_pkg::WAKE_WITH_ID_CYC + fwid_pkg::SYNC_MARGIN_CYC;  // see RULE7
          else hold_cnt <= fwid_pkg::WAKE_RELEASE_CYC + fwid_pkg::SYNC_MARGIN_CYC;  // see RULE3
          state <= H_HOLD;
        end
        H_HOLD: if (hold_cnt == 16'h0000) begin
          busy <= 1'b0;
          state <= H_IDLE;
        end else begin
          hold_cnt <= hold_cnt - 16'h0001;
        end
      endcase
    end
  end

  assign link.cs_n = cs_q;
  assign link.sclk = sclk_q;
  assign link.host_io_o = io_o;
  assign link.host_io_oe = io_oe;
endmodule

// File: include/fwid_link_if.sv
// Serial flash link: chip select, serial clock and four data lines.
// Resolves the shared data wires from both enables; idle lines pull high.
`timescale 1ns/1ps
interface fwid_link_if;
  logic cs_n;
  logic sclk;
  logic [3:0] host_io_o;
  logic [3:0] host_io_oe;
  logic [3:0] dev_io_o;
  logic [3:0] dev_io_oe;
  logic [3:0] io;

  // Wire level from whichever end drives
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      if (dev_io_oe[i]) io[i] = dev_io_o[i];
      else if (host_io_oe[i]) io[i] = host_io_o[i];
      else io[i] = 1'b1;
    end
  end

  modport host (output cs_n, output sclk, output host_io_o, output host_io_oe, input io);
  modport dev (input cs_n, input sclk, input io, output dev_io_o, output dev_io_oe);
endinterface

// File: include/fwid_pkg.sv
// Shared constants for the flash wake/identify/quad-mode link.
// Assumes a 100 MHz system clock on both ends of the link.
package fwid_pkg;
  // Opcodes
  localparam logic [7:0] OP_WAKE_ID = 8'hab;
  localparam logic [7:0] OP_QUAD_ON = 8'h38;
  localparam logic [7:0] OP_QUAD_OFF = 8'hff;
  localparam logic [7:0] OP_PARAM_TABLE = 8'h5a;
  localparam logic [7:0] OP_READ = 8'h03;
  localparam logic [7:0] OP_WREN = 8'h06;
  localparam logic [7:0] OP_RESET_EN = 8'h66;
  localparam logic [7:0] OP_RESET = 8'h99;
  // Byte counts after the opcode, bits per byte and step, erased byte value
  localparam logic [2:0] ID_DUMMY_BYTES = 3'h3;
  localparam logic [2:0] PARAM_LEAD_BYTES = 3'h4;
  localparam logic [2:0] PARAM_ADDR_LAST_LEFT = 3'h2;
  localparam logic [2:0] READ_ADDR_BYTES = 3'h3;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] STEP_SINGLE = 4'h1;
  localparam logic [3:0] STEP_QUAD = 4'h4;
  localparam logic [7:0] ERASED_BYTE = 8'hff;
  // Status register layout and delivered value
  localparam int STATUS_W = 24;
  localparam int STS_BUSY_BIT = 0;
  localparam int STS_WEL_BIT = 1;
  localparam int STS_QUAD_EN_BIT = 9;
  localparam int STS_DRIVE_LOW_BIT = 21;
  localparam logic [23:0] STATUS_DELIVERED =
    (24'h1 << STS_DRIVE_LOW_BIT) | (24'h1 << STS_QUAD_EN_BIT);
  // Timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int WAKE_RELEASE_NS = 3000;
  localparam int WAKE_WITH_ID_NS = 5000;
  localparam logic [15:0] WAKE_RELEASE_CYC =
    16'((WAKE_RELEASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [15:0] WAKE_WITH_ID_CYC =
    16'((WAKE_WITH_ID_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [15:0] SYNC_MARGIN_CYC = 16'h0008;
  localparam logic [15:0] CS_HIGH_MIN_CYC = 16'h0004;
  localparam int SCLK_HALF_CYC = 16;
  // Host register map (byte addresses) and fields
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_DATA = 4'h8;
  localparam int CTRL_OP_LSB = 0;
  localparam int CTRL_DUMMY_LSB = 8;
  localparam int CTRL_LEN_LSB = 12;
  localparam int CTRL_WAKE_BIT = 16;
  localparam int HST_BUSY_BIT = 0;
  localparam int HST_QUAD_BIT = 1;
endpackage

// File: sim/fwid_props.sv
// Checker for the flash link: watches the wires and the device's state pins.
// Assumes one clock domain and instantiation in tb_top beside the interface.
`timescale 1ns/1ps
module fwid_props (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic [3:0] dev_io_o,
  input wire logic [3:0] dev_io_oe,
  input wire logic operation_busy_flag_i,
  input wire logic quad_instruction_mode_o,
  input wire logic deep_power_down_o,
  input wire logic wake_pending_o
);
  logic [9:0] pend_cnt;

  // Length of the running release delay
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) pend_cnt <= 10'h000;
    else if (wake_pending_o) pend_cnt <= pend_cnt + 10'h001;
    else pend_cnt <= 10'h000;
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  // Wake leaves power-down and starts the delay
  AST_WAKE_STARTS_DELAY: assert property ($fell(deep_power_down_o) |-> ##[0:2] wake_pending_o)
    else $error("power-down left without a release delay");
  AST_DELAY_LENGTH: assert property ($fell(wake_pending_o) |->
    (pend_cnt == 10'(fwid_pkg::WAKE_RELEASE_CYC) ||
    pend_cnt == 10'(fwid_pkg::WAKE_WITH_ID_CYC)))
    else $error("release delay of wrong length");
  AST_DELAY_QUIET: assert property (wake_pending_o |-> dev_io_oe == 4'h0)
    else $error("device drives during release delay");
  AST_CS_HELD_HIGH: assert property (wake_pending_o |-> cs_n)
    else $error("chip select low during release delay");
  AST_DATA_ON_FALL: assert property ((dev_io_oe != 4'h0) && $changed(dev_io_o) |-> !sclk)
    else $error("device data changed while serial clock high");
  AST_CS_ENDS_DRIVE: assert property ($rose(cs_n) |-> ##[1:8] dev_io_oe == 4'h0)
    else $error("device still drives after chip select rose");
  AST_BUSY_KEEPS_PD: assert property (operation_busy_flag_i && deep_power_down_o
    |=> deep_power_down_o)
    else $error("power-down left while busy");
  AST_MODE_AT_CS_HIGH: assert property ($changed(quad_instruction_mode_o) |-> cs_n)
    else $error("mode changed inside a frame");
endmodule

// File: sim/tb_top.sv
// Testbench: host controller and flash device joined over the link.
// Software access is modelled by Avalon-MM tasks with waitrequest.
`timescale 1ns/1ps
module tb_top;
  localparam logic [7:0] ID = 8'ha7;  // Arbitrary value
  localparam logic [63:0] PTAB = 64'h1122334455667788;
  logic clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic busy_flag = 1'b0;
  logic enter_pd = 1'b0;
  logic quad, pd, pend;
  logic [23:0] status;
  logic [31:0] d;
  int n_errors = 0;
  int checks_done = 0;

  // 100 MHz clock
  always #5 clk_i = ~clk_i;

  fwid_link_if link();
  fwid_host_ctrl i_fwid_host_ctrl (.clk_i(clk_i), .resetn_i(resetn_i),
    .avs_address_i(avs_address), .avs_read_i(avs_read), .avs_write_i(avs_write),
    .avs_writedata_i(avs_writedata), .avs_readdata_o(avs_readdata),
    .avs_waitrequest_o(avs_waitrequest), .link(link.host));
  fwid_flash_dev #(.IDENTITY_BYTE(ID), .PARAM_BYTES(8), .PARAM_TABLE(PTAB)) i_fwid_flash_dev (
    .clk_i(clk_i), .resetn_i(resetn_i), .link(link.dev), .operation_busy_flag_i(busy_flag),
    .enter_power_down_i(enter_pd), .quad_instruction_mode_o(quad),
    .deep_power_down_o(pd), .wake_pending_o(pend), .status_o(status));
  fwid_props i_fwid_props (.clk_i(clk_i), .resetn_i(resetn_i), .cs_n(link.cs_n),
    .sclk(link.sclk), .dev_io_o(link.dev_io_o), .dev_io_oe(link.dev_io_oe),
    .operation_busy_flag_i(busy_flag), .quad_instruction_mode_o(quad),
    .deep_power_down_o(pd), .wake_pending_o(pend));

  // Counts and verdict
  task results;
    $display("checks=%0d errors=%0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One Avalon access; request held until waitrequest is seen low
  task automatic bus(input logic [3:0] a, input logic wr, input logic [31:0] wd,
                     output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge clk_i);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= wd;
    do begin
      @(posedge clk_i);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 1000);
    if (n >= 1000) chk(32'h0, 32'h1);
    // Taken at the edge where waitrequest is seen low
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  // Launch one frame, wait for it to finish, fetch received bytes
  task automatic run_cmd(input logic [7:0] op, input logic [2:0] lead,
                         input logic [2:0] nrd, input logic wake, output logic [31:0] rd);
    int n;
    n = 0;
    bus(fwid_pkg::REG_CTRL, 1'b1, {15'h0, wake, 1'b0, nrd, 1'b0, lead, op}, rd);
    do begin
      bus(fwid_pkg::REG_STATUS, 1'b0, 32'h0, rd);
      n++;
    end while (rd[fwid_pkg::HST_BUSY_BIT] !== 1'b0 && n < 5000);
    if (n >= 5000) chk(32'h0, 32'h1);
    bus(fwid_pkg::REG_DATA, 1'b0, 32'h0, rd);
  endtask

  // Pulse the power-down request
  task power_down;
    @(posedge clk_i);
    enter_pd <= 1'b1;
    @(posedge clk_i);
    enter_pd <= 1'b0;
    repeat (4) @(posedge clk_i);
  endtask

  // Main sequence
  initial begin
    repeat (10) @(posedge clk_i);
    resetn_i <= 1'b1;
    @(posedge clk_i);
    chk({8'h0, status}, {8'h0, fwid_pkg::STATUS_DELIVERED});
    run_cmd(fwid_pkg::OP_WAKE_ID, 3'h3, 3'h2, 1'b0, d);
    chk(d, {16'h0, ID, ID});
    run_cmd(fwid_pkg::OP_READ, 3'h3, 3'h4, 1'b0, d);
    chk(d, 32'hffffffff);
    run_cmd(fwid_pkg::OP_PARAM_TABLE, 3'h4, 3'h4, 1'b0, d);
    chk(d, PTAB[63:32]);
    run_cmd(fwid_pkg::OP_WREN, 3'h0, 3'h0, 1'b0, d);
    run_cmd(fwid_pkg::OP_QUAD_ON, 3'h0, 3'h0, 1'b0, d);
    chk({31'h0, quad}, 32'h1);
    chk({31'h0, status[fwid_pkg::STS_WEL_BIT]}, 32'h1);
    run_cmd(fwid_pkg::OP_WAKE_ID, 3'h3, 3'h1, 1'b0, d);
    chk(d, {24'h0, ID});
    run_cmd(fwid_pkg::OP_QUAD_OFF, 3'h0, 3'h0, 1'b0, d);
    chk({31'h0, quad}, 32'h0);
    chk({31'h0, status[fwid_pkg::STS_WEL_BIT]}, 32'h1);
    power_down();
    run_cmd(fwid_pkg::OP_QUAD_ON, 3'h0, 3'h0, 1'b0, d);
    chk({30'h0, pd, quad}, 32'h2);
    // Host flipped its own mode; flip it back, device stays single
    run_cmd(fwid_pkg::OP_QUAD_OFF, 3'h0, 3'h0, 1'b0, d);
    chk({30'h0, pd, quad}, 32'h2);
    busy_flag <= 1'b1;
    run_cmd(fwid_pkg::OP_WAKE_ID, 3'h0, 3'h0, 1'b1, d);
    chk({31'h0, pd}, 32'h1);
    busy_flag <= 1'b0;
    run_cmd(fwid_pkg::OP_WAKE_ID, 3'h0, 3'h0, 1'b1, d);
    chk({30'h0, pd, pend}, 32'h0);
    run_cmd(fwid_pkg::OP_QUAD_ON, 3'h0, 3'h0, 1'b0, d);
    chk({31'h0, quad}, 32'h1);
    run_cmd(fwid_pkg::OP_QUAD_OFF, 3'h0, 3'h0, 1'b0, d);
    power_down();
    run_cmd(fwid_pkg::OP_WAKE_ID, 3'h3, 3'h1, 1'b1, d);
    chk({d[23:0], 7'h0, pd}, {16'h0, ID, 8'h0});
    bus(4'hc, 1'b0, 32'h0, d);
    chk(d, 32'h0);
    results();
  end

  // Watchdog
  initial begin
    repeat (80000) @(posedge clk_i);
    n_errors++;
    $display("ERROR %0t: run did not finish", $time);
    results();
  end
endmodule
